// File: rtl/spl_loader.sv
// setup memory pack loader: power-up copy pack to backup, commanded copy backup to pack
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - the pack is used as data source only with the pack-load select switch on.
// - switch off means no copy at start-up; backup contents stay as they are.
// - with the switch on, pack presence is checked before any transfer begins.
// - a present pack is copied whole into backup memory at power-up.
// - after a copy the backup data is used later, pack or no pack.
// - a write-protected pack receives no writes and no error is reported.
// - the power-up copy runs regardless of the write-protect switch.
// - the status indicator blinks while data comes from the pack.
// - in expansion operation command codes f0..f8 start a write to the pack.
// - in standalone operation coils 400..415 start a write to the pack.
// - the pack store addressed holds up to 128 kB.
// - the indicator shows backup activity to internal memory and to the pack.
// - the indicator is held on while settings are copied from backup memory to the pack.
module spl_loader
	import spl_pkg::*;
#(
	parameter int PACK_BYTES     = SPL_PACK_BYTES,
	parameter int BLINK_HALF_CYC = SPL_BLINK_HALF_CYC
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [SPL_APB_AW-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	// straps and pack sense
	input  wire logic                  pack_load_select_switch,
	input  wire logic                  standalone_mode,
	input  wire logic                  pack_present,
	input  wire logic                  pack_write_protect,
	// pack memory port
	output var  spl_mem_req_t          pack_mem,
	input  wire logic                  pack_ack,
	input  wire logic [SPL_DATA_W-1:0] pack_rdata,
	// internal backup memory port
	output var  spl_mem_req_t          bkp_mem,
	input  wire logic                  bkp_ack,
	input  wire logic [SPL_DATA_W-1:0] bkp_rdata,
	// front panel
	output var  logic                  backup_status_indicator
);

	// ==========================================================================
	// elaboration checks
	// ==========================================================================
	if (PACK_BYTES < 1 || PACK_BYTES > (1 << SPL_ADDR_W)) begin : g_bad_size
		$error("PACK_BYTES outside the addressable pack store");
	end
	if (BLINK_HALF_CYC < 1) begin : g_bad_blink
		$error("BLINK_HALF_CYC must be at least one");
	end

	localparam logic [SPL_ADDR_W-1:0] LAST_ADDR = SPL_ADDR_W'(PACK_BYTES - 1);
	localparam logic [31:0]           BLINK_TOP = 32'(BLINK_HALF_CYC - 1);

	// ==========================================================================
	// state
	// ==========================================================================
	spl_state_t             state_reg, state_next;
	logic [SPL_ADDR_W-1:0]  addr_reg, addr_next;
	logic [SPL_DATA_W-1:0]  data_reg, data_next;
	spl_mem_req_t           pack_reg, pack_next;
	spl_mem_req_t           bkp_reg, bkp_next;
	logic                   load_done_reg, load_done_next;
	logic [7:0]             cmd_reg, cmd_next;
	logic                   cmd_pend_reg, cmd_pend_next;
	logic [15:0]            coil_reg, coil_next;
	logic [15:0]            coil_take_reg, coil_take_next;
	logic [31:0]            blink_cnt_reg, blink_cnt_next;
	logic                   blink_reg, blink_next;
	logic                   led_reg, led_next;
	logic [31:0]            prdata_reg, prdata_next;
	logic                   pready_reg, pready_next;
	logic                   pslverr_reg, pslverr_next;

	logic setup_ph;
	logic wr_cmd;
	logic wr_coil;
	logic save_req;
	logic save_start;
	logic save_end;

	// apb decode: a transfer is answered one cycle after its setup phase
	assign setup_ph = psel & ~penable;
	assign wr_cmd   = setup_ph & pwrite & (paddr == SPL_OFS_CMD);
	assign wr_coil  = setup_ph & pwrite & (paddr == SPL_OFS_COIL);

	// source of a pack write depends on the operating mode
	assign save_req = standalone_mode ? (|coil_reg) : cmd_pend_reg;
	assign save_start = (state_reg == SPL_S_IDLE) & save_req;
	assign save_end = (state_reg == SPL_S_SV_WR) & (addr_reg == LAST_ADDR)
		& (pack_write_protect | (pack_reg.req & pack_ack));

	// ==========================================================================
	// transfer sequencer
	// ==========================================================================
	// each memory access raises req, holds it until ack, then drops it one cycle
	always_comb begin
		state_next     = state_reg;
		addr_next      = addr_reg;
		data_next      = data_reg;
		pack_next      = pack_reg;
		bkp_next       = bkp_reg;
		load_done_next = load_done_reg;
		unique case (state_reg)
			SPL_S_START: begin
				addr_next = '0;
				// presence is looked at only with the select switch on
				if (pack_load_select_switch && pack_present) begin
					state_next = SPL_S_LD_RD;
				end else begin
					state_next = SPL_S_IDLE;
				end
			end
			SPL_S_LD_RD: begin
				if (!pack_reg.req) begin
					pack_next.req  = 1'b1;
					pack_next.we   = 1'b0;
					pack_next.addr = addr_reg;
				end else if (pack_ack) begin
					pack_next.req = 1'b0;
					data_next     = pack_rdata;
					state_next    = SPL_S_LD_WR;
				end
			end
			SPL_S_LD_WR: begin
				if (!bkp_reg.req) begin
					bkp_next.req   = 1'b1;
					bkp_next.we    = 1'b1;
					bkp_next.addr  = addr_reg;
					bkp_next.wdata = data_reg;
				end else if (bkp_ack) begin
					bkp_next.req = 1'b0;
					if (addr_reg == LAST_ADDR) begin
						load_done_next = 1'b1;
						state_next     = SPL_S_IDLE;
					end else begin
						addr_next  = addr_reg + SPL_ADDR_W'(1);
						state_next = SPL_S_LD_RD;
					end
				end
			end
			SPL_S_IDLE: begin
				addr_next = '0;
				if (save_req) begin
					state_next = SPL_S_SV_RD;
				end
			end
			SPL_S_SV_RD: begin
				if (!bkp_reg.req) begin
					bkp_next.req  = 1'b1;
					bkp_next.we   = 1'b0;
					bkp_next.addr = addr_reg;
				end else if (bkp_ack) begin
					bkp_next.req = 1'b0;
					data_next    = bkp_rdata;
					state_next   = SPL_S_SV_WR;
				end
			end
			SPL_S_SV_WR: begin
				// protected pack: step on silently, nothing ever reaches the pins
				if (pack_write_protect) begin
					if (addr_reg == LAST_ADDR) begin
						state_next = SPL_S_IDLE;
					end else begin
						addr_next  = addr_reg + SPL_ADDR_W'(1);
						state_next = SPL_S_SV_RD;
					end
				end else if (!pack_reg.req) begin
					pack_next.req   = 1'b1;
					pack_next.we    = 1'b1;
					pack_next.addr  = addr_reg;
					pack_next.wdata = data_reg;
				end else if (pack_ack) begin
					pack_next.req = 1'b0;
					if (addr_reg == LAST_ADDR) begin
						state_next = SPL_S_IDLE;
					end else begin
						addr_next  = addr_reg + SPL_ADDR_W'(1);
						state_next = SPL_S_SV_RD;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_reg     <= SPL_S_START;
			addr_reg      <= '0;
			data_reg      <= '0;
			pack_reg      <= '0;
			bkp_reg       <= '0;
			load_done_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			addr_reg      <= addr_next;
			data_reg      <= data_next;
			pack_reg      <= pack_next;
			bkp_reg       <= bkp_next;
			load_done_reg <= load_done_next;
		end
	end

	// ==========================================================================
	// command and coil registers
	// ==========================================================================
	// a new request in the cycle its predecessor is taken is kept (set wins)
	always_comb begin
		cmd_next       = cmd_reg;
		cmd_pend_next  = cmd_pend_reg;
		coil_take_next = coil_take_reg;
		coil_next      = coil_reg;
		if (save_start) begin
			cmd_pend_next  = 1'b0;
			coil_take_next = coil_reg;
		end
		if (save_end) begin
			coil_next = coil_reg & ~coil_take_reg;
			coil_take_next = '0;
		end
		if (wr_cmd) begin
			cmd_next = pwdata[7:0];
			if (pwdata[7:0] >= SPL_CMD_FIRST && pwdata[7:0] <= SPL_CMD_LAST) begin
				cmd_pend_next = 1'b1;
			end
		end
		if (wr_coil) begin
			coil_next = (save_end ? (coil_reg & ~coil_take_reg) : coil_reg)
				| pwdata[15:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cmd_reg       <= SPL_CMD_RST;
			cmd_pend_reg  <= 1'b0;
			coil_reg      <= SPL_COIL_RST;
			coil_take_reg <= '0;
		end else begin
			cmd_reg       <= cmd_next;
			cmd_pend_reg  <= cmd_pend_next;
			coil_reg      <= coil_next;
			coil_take_reg <= coil_take_next;
		end
	end

	// ==========================================================================
	// status indicator
	// ==========================================================================
	// blink divider runs only during the load, so each load starts with the lamp on
	always_comb begin
		blink_cnt_next = '0;
		blink_next     = 1'b1;
		led_next       = 1'b0;
		if (state_reg == SPL_S_LD_RD || state_reg == SPL_S_LD_WR) begin
			blink_next = blink_reg;
			if (blink_cnt_reg == BLINK_TOP) begin
				blink_next = ~blink_reg;
			end else begin
				blink_cnt_next = blink_cnt_reg + 32'd1;
			end
			led_next = blink_reg;
		end else if (state_reg == SPL_S_SV_RD || state_reg == SPL_S_SV_WR) begin
			led_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			blink_cnt_reg <= '0;
			blink_reg     <= 1'b1;
			led_reg       <= 1'b0;
		end else begin
			blink_cnt_reg <= blink_cnt_next;
			blink_reg     <= blink_next;
			led_reg       <= led_next;
		end
	end

	// ==========================================================================
	// apb read path
	// ==========================================================================
	// read data is prepared in the setup phase so the answer leaves a flop
	always_comb begin
		prdata_next  = prdata_reg;
		pready_next  = setup_ph;
		pslverr_next = 1'b0;
		if (setup_ph) begin
			prdata_next = '0;
			unique case (paddr)
				SPL_OFS_CMD: begin
					prdata_next[7:0] = cmd_reg;
				end
				SPL_OFS_COIL: begin
					prdata_next[15:0] = coil_reg;
				end
				SPL_OFS_STAT: begin
					prdata_next[SPL_ST_LOADING] = (state_reg == SPL_S_LD_RD)
						| (state_reg == SPL_S_LD_WR);
					prdata_next[SPL_ST_SAVING] = (state_reg == SPL_S_SV_RD)
						| (state_reg == SPL_S_SV_WR);
					prdata_next[SPL_ST_LOAD_DONE]  = load_done_reg;
					prdata_next[SPL_ST_SELECT]     = pack_load_select_switch;
					prdata_next[SPL_ST_PRESENT]    = pack_present;
					prdata_next[SPL_ST_STANDALONE] = standalone_mode;
					prdata_next[SPL_ST_CMD_PEND]   = cmd_pend_reg;
				end
				default: begin
					pslverr_next = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// ==========================================================================
	// outputs
	// ==========================================================================
	assign prdata   = prdata_reg;
	assign pready   = pready_reg;
	assign pslverr  = pslverr_reg;
	assign pack_mem = pack_reg;
	assign bkp_mem  = bkp_reg;
	assign backup_status_indicator = led_reg;

endmodule

`default_nettype wire

// File: rtl/spl_pkg.sv
// shared constants and types for the setup memory pack loader
`default_nettype none

package spl_pkg;

	// ==========================================================================
	// storage geometry
	// ==========================================================================
	localparam int SPL_ADDR_W     = 17;       // byte address into the pack store
	localparam int SPL_DATA_W     = 8;        // one byte per transfer
	localparam int SPL_PACK_BYTES = 131072;   // 128 kB of setup data

	// ==========================================================================
	// timing
	// ==========================================================================
	localparam int SPL_CLK_MHZ       = 200;
	localparam int SPL_BLINK_HALF_MS = 250;   // blink half period in ms
	localparam int SPL_BLINK_HALF_CYC = SPL_BLINK_HALF_MS * 1000 * SPL_CLK_MHZ;

	// ==========================================================================
	// register map (byte addresses on the apb bus)
	// ==========================================================================
	localparam int SPL_APB_AW = 12;
	localparam logic [11:0] SPL_OFS_CMD  = 12'h000;
	localparam logic [11:0] SPL_OFS_COIL = 12'h004;
	localparam logic [11:0] SPL_OFS_STAT = 12'h008;

	// command codes that request a write to the pack
	localparam logic [7:0] SPL_CMD_FIRST = 8'hf0;
	localparam logic [7:0] SPL_CMD_LAST  = 8'hf8;

	// output coils 400..415 occupy bits 0..15 of the coil register
	localparam int SPL_COIL_BASE  = 400;
	localparam int SPL_COIL_COUNT = 16;

	// status register bit positions
	localparam int SPL_ST_LOADING   = 0;
	localparam int SPL_ST_SAVING    = 1;
	localparam int SPL_ST_LOAD_DONE = 2;
	localparam int SPL_ST_SELECT    = 3;
	localparam int SPL_ST_PRESENT   = 4;
	localparam int SPL_ST_STANDALONE = 5;
	localparam int SPL_ST_CMD_PEND  = 6;

	// reset values
	localparam logic [7:0]  SPL_CMD_RST  = 8'h00;
	localparam logic [15:0] SPL_COIL_RST = 16'h0000;

	// ==========================================================================
	// types
	// ==========================================================================
	typedef struct packed {
		logic                  req;
		logic                  we;
		logic [SPL_ADDR_W-1:0] addr;
		logic [SPL_DATA_W-1:0] wdata;
	} spl_mem_req_t;

	typedef enum logic [2:0] {
		SPL_S_START,
		SPL_S_LD_RD,
		SPL_S_LD_WR,
		SPL_S_IDLE,
		SPL_S_SV_RD,
		SPL_S_SV_WR
	} spl_state_t;

endpackage

`default_nettype wire

// File: verification/spl_loader_asserts.sv
// port checker for the setup memory pack loader
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// checker
module spl_loader_asserts
	import spl_pkg::*;
#(
	parameter int BLINK_HALF_CYC = 3
) (
	input wire logic                  clk_sys,
	input wire logic                  rst_b,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic [SPL_APB_AW-1:0] paddr,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  pack_load_select_switch,
	input wire logic                  pack_present,
	input wire logic                  pack_write_protect,
	input wire spl_mem_req_t          pack_mem,
	input wire logic                  pack_ack,
	input wire logic [SPL_DATA_W-1:0] pack_rdata,
	input wire spl_mem_req_t          bkp_mem,
	input wire logic                  bkp_ack,
	input wire logic [SPL_DATA_W-1:0] bkp_rdata,
	input wire logic                  backup_status_indicator
);
	logic [7:0] run_reg, run_next, pk_reg, pk_next, bk_reg, bk_next;
	logic       lamp_reg;

	// cycles since the lamp last moved; saturates so idle spells never wrap
	always_comb begin
		run_next = (backup_status_indicator != lamp_reg) ? 8'h00 : run_reg + {7'h00, run_reg != 8'hff};
		pk_next  = pack_ack ? pack_rdata : pk_reg;
		bk_next  = bkp_ack ? bkp_rdata : bk_reg;
	end
	always_ff @(posedge clk_sys) begin
		lamp_reg <= backup_status_indicator;
		run_reg  <= run_next;
		pk_reg   <= pk_next;
		bk_reg   <= bk_next;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	chk_wp_no_write: assert property (pack_write_protect |-> !(pack_mem.req && pack_mem.we))
		else $error("pack written while protected");
	chk_read_gated: assert property (pack_mem.req && !pack_mem.we |-> pack_load_select_switch && pack_present)
		else $error("pack read without switch and pack");
	chk_no_load: assert property (!(pack_load_select_switch && pack_present) |-> !(bkp_mem.req && bkp_mem.we))
		else $error("backup written with load disabled");
	chk_load_copy: assert property (pack_ack && pack_mem.req && !pack_mem.we |-> ##[1:6] (bkp_mem.req && bkp_mem.we && bkp_mem.wdata == pk_reg))
		else $error("pack byte not copied to backup");
	chk_save_copy: assert property (bkp_ack && bkp_mem.req && !bkp_mem.we && !pack_write_protect |-> ##[1:6] (pack_mem.req && pack_mem.we && pack_mem.wdata == bk_reg))
		else $error("backup byte not copied to pack");
	chk_req_hold: assert property (pack_mem.req && !pack_ack |=> pack_mem.req && $stable(pack_mem.addr))
		else $error("pack request dropped before answer");
	chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
	chk_apb_unmapped: assert property (psel && !penable && paddr > SPL_OFS_STAT |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_lamp_blink: assert property (bkp_mem.req && bkp_mem.we |-> run_reg <= BLINK_HALF_CYC)
		else $error("lamp not blinking during load");
	chk_lamp_save: assert property (bkp_mem.req && !bkp_mem.we |=> backup_status_indicator)
		else $error("lamp off during save");
endmodule

`default_nettype wire

// File: verification/spl_mem_pair.sv
// behavioural pack memory and backup memory seen from the loader
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// memory pair: index 0 is the pack, index 1 the backup
module spl_mem_pair
	import spl_pkg::*;
#(
	parameter int NB = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic [1:0]   lat,
	input  wire spl_mem_req_t pack_mem,
	input  wire spl_mem_req_t bkp_mem,
	output var  logic         pack_ack,
	output var  logic         bkp_ack,
	output var  logic [7:0]   pack_rdata,
	output var  logic [7:0]   bkp_rdata
);
	logic [7:0]   store [2][NB];
	logic [7:0]   rdata [2];
	logic [1:0]   wait_cnt [2];
	logic [1:0]   busy, ack;
	spl_mem_req_t rq [2];

	assign rq[0]      = pack_mem;
	assign rq[1]      = bkp_mem;
	assign pack_ack   = ack[0];
	assign bkp_ack    = ack[1];
	assign pack_rdata = rdata[0];
	assign bkp_rdata  = rdata[1];

	// one answer per request after lat cycles; busy stops a second answer while req lingers
	always @(posedge clk_sys) begin
		for (int k = 0; k < 2; k++) begin
			ack[k] <= 1'b0;
			rdata[k] <= ~rdata[k]; // read data is not held past the answer
			if (!rst_b || !rq[k].req) begin
				busy[k] <= 1'b0;
				wait_cnt[k] <= 2'h0;
				if (!rst_b) rdata[k] <= 8'h3c;
			end else if (!busy[k] && wait_cnt[k] < lat) begin
				wait_cnt[k] <= wait_cnt[k] + 2'h1;
			end else if (!busy[k]) begin
				ack[k] <= 1'b1;
				busy[k] <= 1'b1;
				if (rq[k].we) store[k][rq[k].addr % NB] <= rq[k].wdata;
				else rdata[k] <= store[k][rq[k].addr % NB];
			end
		end
	end
endmodule

`default_nettype wire

// File: verification/spl_loader_tb.sv
// self-checking bench for the setup memory pack loader
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// bench top
module spl_loader_tb
	import spl_pkg::*;
;
	localparam int NB = 8;
	localparam int BH = 3;
	logic         clk_sys, rst_b, psel, penable, pwrite, sel_sw, stand, present, wp, lamp, lamp_d, err;
	logic         pready, pslverr, pack_ack, bkp_ack;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [7:0]   pack_rdata, bkp_rdata, snp [NB], snb [NB];
	logic [1:0]   lat;
	spl_mem_req_t pack_mem, bkp_mem;
	int           num_errors, total_checks, seed, toggles, cycles;

	spl_loader #(.PACK_BYTES(NB), .BLINK_HALF_CYC(BH)) spl_loader_inst (.clk_sys(clk_sys), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pack_load_select_switch(sel_sw), .standalone_mode(stand),
		.pack_present(present), .pack_write_protect(wp), .pack_mem(pack_mem), .pack_ack(pack_ack),
		.pack_rdata(pack_rdata), .bkp_mem(bkp_mem), .bkp_ack(bkp_ack), .bkp_rdata(bkp_rdata),
		.backup_status_indicator(lamp));
	spl_mem_pair #(.NB(NB)) spl_mem_pair_inst (.clk_sys(clk_sys), .rst_b(rst_b), .lat(lat),
		.pack_mem(pack_mem), .bkp_mem(bkp_mem), .pack_ack(pack_ack), .bkp_ack(bkp_ack),
		.pack_rdata(pack_rdata), .bkp_rdata(bkp_rdata));

	function automatic logic is_save(input logic [7:0] c);
		return c >= SPL_CMD_FIRST && c <= SPL_CMD_LAST;
	endfunction
	function automatic logic [31:0] exp_stat(input logic dn, input logic s, input logic p, input logic a);
		return {26'h0, a, p, s, dn, 2'b00};
	endfunction

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_mem(input int d, input logic [7:0] e [NB]);
		for (int i = 0; i < NB; i++) chk({24'h0, spl_mem_pair_inst.store[d][i]}, {24'h0, e[i]});
	endtask
	// apb master: held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll until no load, save or pending request remains
	task automatic wait_idle();
		logic [31:0] st;
		do begin
			apb(1'b0, SPL_OFS_STAT, 32'h0);
			st = rd;
			apb(1'b0, SPL_OFS_COIL, 32'h0);
		end while (st[1:0] !== 2'b00 || st[6] !== 1'b0 || rd !== 32'h0);
	endtask
	task automatic fill();
		for (int i = 0; i < NB; i++) begin
			spl_mem_pair_inst.store[0][i] = 8'($random(seed));
			spl_mem_pair_inst.store[1][i] = 8'($random(seed));
		end
		snp = spl_mem_pair_inst.store[0];
		snb = spl_mem_pair_inst.store[1];
	endtask
	task automatic boot(input logic s, input logic p, input logic w, input logic a);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		sel_sw <= s;
		present <= p;
		wp <= w;
		stand <= a;
		repeat (5) @(posedge clk_sys);
		toggles = 0;
		rst_b <= 1'b1;
		wait_idle();
		apb(1'b0, SPL_OFS_STAT, 32'h0);
	endtask

	// ============================================================
	// clock, lamp activity, latency and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		lamp_d <= lamp;
		lat <= 2'($random(seed));
		if (lamp !== lamp_d) toggles++;
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			end_of_test();
		end
	end

	// ============================================================
	// scenarios
	initial begin
		seed = 44;
		{rst_b, psel, penable, pwrite, sel_sw, stand, present, wp, lat, paddr, pwdata} = '0;
		// load with protect off then on, then commands around the save range
		for (int w = 0; w < 2; w++) begin
			fill();
			boot(1'b1, 1'b1, w[0], 1'b0);
			chk(rd, exp_stat(1'b1, 1'b1, 1'b1, 1'b0));
			chk_mem(1, snp);
			chk({31'h0, toggles > 1}, 32'h1);
			chk({31'h0, lamp}, 32'h0);
			for (int c = 'hef; c <= 'hf9; c++) begin
				fill();
				apb(1'b1, SPL_OFS_CMD, c);
				apb(1'b0, SPL_OFS_CMD, 32'h0);
				chk(rd, c);
				wait_idle();
				if (is_save(8'(c)) && w == 0)
					chk_mem(0, snb);
				else
					chk_mem(0, snp);
				chk_mem(1, snb);
			end
			$display("load and command test done, protect %0d", w);
		end
		// switch off with pack present: earlier backup kept, then coil saves
		fill();
		boot(1'b0, 1'b1, 1'b0, 1'b1);
		chk(rd, exp_stat(1'b0, 1'b0, 1'b1, 1'b1));
		chk_mem(1, snb);
		for (int i = 0; i <= SPL_COIL_COUNT; i++) begin
			fill();
			apb(1'b1, SPL_OFS_COIL, (i < SPL_COIL_COUNT) ? 32'h1 << i : {16'h0, 16'($random(seed)) | 16'h1});
			wait_idle();
			chk_mem(0, snb);
		end
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("coil test done");
		// switch on but no pack: normal start on existing backup
		fill();
		boot(1'b1, 1'b0, 1'b0, 1'b0);
		chk(rd, exp_stat(1'b0, 1'b1, 1'b0, 1'b0));
		chk_mem(1, snb);
		$display("no pack test done");
		end_of_test();
	end
endmodule

bind spl_loader spl_loader_asserts #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) spl_loader_asserts_inst (.clk_sys(clk_sys),
	.rst_b(rst_b), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pack_load_select_switch(pack_load_select_switch), .pack_present(pack_present),
	.pack_write_protect(pack_write_protect), .pack_mem(pack_mem), .pack_ack(pack_ack), .pack_rdata(pack_rdata),
	.bkp_mem(bkp_mem), .bkp_ack(bkp_ack), .bkp_rdata(bkp_rdata), .backup_status_indicator(backup_status_indicator));

`default_nettype wire
